// >>> rtl/ebfwg_core.sv
// Byte flags, write inhibit, error flag and program timing for the data memory
`timescale 1ns/1ps
`default_nettype none
module ebfwg_core
    import ebfwg_pkg::*;
#(
    parameter int SETTLE_CNT = SETTLE_CYCLES,
    parameter int PROG_CNT = PROG_CYCLES
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire ebfwg_access_t access,
    input wire logic byteFlagEnable,
    input wire logic supplyOk,
    input wire logic errorClear,
    output logic byteFlagReadback,
    output logic inhibit,
    output logic error,
    output logic busy,
    output logic readReady,
    output logic writeReady
);
    localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CNT - 1);
    localparam logic [CNT_W-1:0] PROG_LAST = CNT_W'(PROG_CNT - 1);

    // Flags clear and readback high straight out of reset
    localparam ebfwg_state_t RESET_STATE = '{
        flags: '0,
        flagReadback: 1'b1,
        inhibit: 1'b0,
        settleCount: '0,
        error: 1'b0,
        progState: EBFWG_IDLE,
        progCount: '0
    };

    ebfwg_state_t state;
    ebfwg_state_t next_state;

    function automatic logic inFlagRange(input logic [15:0] a);
        return (a >= FLAG_BASE) && (a <= FLAG_LAST);
    endfunction

    function automatic logic [FLAG_IDX_W-1:0] flagIndex(input logic [15:0] a);
        return a[FLAG_IDX_W-1:0];
    endfunction

    logic writeTaken;
    logic writeFails;

    // A write is only taken when idle; one that meets inhibit low (supply low or not yet settled) fails
    assign writeTaken = access.wrEn && (state.progState == EBFWG_IDLE);
    assign writeFails = writeTaken && !state.inhibit;

    always_comb begin
        next_state = state;
        if (!byteFlagEnable) begin
            next_state.flags = '0;
            next_state.flagReadback = 1'b1;
        end else begin
            if (writeTaken && !writeFails && inFlagRange(access.addr)) begin
                next_state.flags[flagIndex(access.addr)] = 1'b1;
            end
            if (access.rdEn && inFlagRange(access.addr)) begin
                next_state.flagReadback = state.flags[flagIndex(access.addr)];
            end
        end
        if (!supplyOk) begin
            next_state.inhibit = 1'b0;
            next_state.settleCount = '0;
        end else if (!state.inhibit) begin
            if (state.settleCount == SETTLE_LAST) begin
                next_state.inhibit = 1'b1;
            end else begin
                next_state.settleCount = state.settleCount + 1'b1;
            end
        end
        // Set wins over a clear in the same cycle
        if (errorClear) begin
            next_state.error = 1'b0;
        end
        case (state.progState)
            EBFWG_IDLE: begin
                if (writeFails) begin
                    next_state.error = 1'b1;
                end else if (writeTaken) begin
                    next_state.progState = EBFWG_PROG;
                    next_state.progCount = '0;
                end
            end
            EBFWG_PROG: begin
                if (!supplyOk) begin
                    // Supply dropped mid-program: error set and back to idle; a flag the write set stays set
                    next_state.error = 1'b1;
                    next_state.progState = EBFWG_IDLE;
                end else if (state.progCount == PROG_LAST) begin
                    next_state.progState = EBFWG_IDLE;
                end else begin
                    next_state.progCount = state.progCount + 1'b1;
                end
            end
            default: next_state.progState = EBFWG_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state <= RESET_STATE;
        end else begin
            state <= next_state;
        end
    end

    assign byteFlagReadback = state.flagReadback;
    assign inhibit = state.inhibit;
    assign error = state.error;
    assign busy = (state.progState == EBFWG_PROG);
    assign readReady = 1'b1;
    assign writeReady = (state.progState == EBFWG_IDLE);
endmodule
`default_nettype wire

// >>> rtl/ebfwg_pkg.sv
// Package for the nonvolatile byte flag and write guard block
package ebfwg_pkg;
    localparam int ADDR_W = 16;
    localparam logic [15:0] FLAG_BASE = 16'h0780;
    localparam logic [15:0] FLAG_LAST = 16'h07FF;
    localparam int FLAG_COUNT = 128;
    localparam int FLAG_IDX_W = 7;
    localparam int CLK_PERIOD_NS = 10;
    localparam int SETTLE_TIME_MS = 2;
    localparam int PROG_TIME_MS = 10;
    localparam int SETTLE_CYCLES = (SETTLE_TIME_MS * 1000000) / CLK_PERIOD_NS;
    localparam int PROG_CYCLES = (PROG_TIME_MS * 1000000) / CLK_PERIOD_NS;
    localparam int CNT_W = 21;

    typedef struct packed {
        logic wrEn;
        logic rdEn;
        logic [15:0] addr;
    } ebfwg_access_t;

    typedef enum logic [1:0] {
        EBFWG_IDLE = 2'b00,
        EBFWG_PROG = 2'b01
    } ebfwg_prog_t;

    typedef struct packed {
        logic [FLAG_COUNT-1:0] flags;
        logic flagReadback;
        logic inhibit;
        logic [CNT_W-1:0] settleCount;
        logic error;
        ebfwg_prog_t progState;
        logic [CNT_W-1:0] progCount;
    } ebfwg_state_t;
endpackage

// >>> testbench/ebfwg_chk.sv
// Port checker for the byte flag and write guard
`timescale 1ns/1ps
`default_nettype none
module ebfwg_chk
    import ebfwg_pkg::*;
#(parameter int SETTLE_CNT = 8, parameter int PROG_CNT = 8) (
    input wire logic clock,
    input wire logic rst_n,
    input wire ebfwg_access_t access,
    input wire logic byteFlagEnable,
    input wire logic supplyOk,
    input wire logic byteFlagReadback,
    input wire logic inhibit,
    input wire logic error,
    input wire logic busy,
    input wire logic readReady,
    input wire logic writeReady
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    wire logic take = access.wrEn && writeReady;
    a_no_wait: assert property (readReady) else $error("stall");
    a_off_one: assert property (!byteFlagEnable |=> byteFlagReadback) else $error("rb");
    a_inh_drop: assert property (!supplyOk |=> !inhibit) else $error("inh");
    // Bench settles in 8 cycles, so a rise needs 8 good cycles behind it
    a_inh_wait: assert property ($rose(inhibit) |-> $past(supplyOk, 8)) else $error("inh");
    a_busy_go: assert property (take && inhibit |=> busy) else $error("busy");
    a_busy_len: assert property ($rose(busy) |-> busy[*8] ##1 !busy) else $error("len");
    a_err_set: assert property (take && !inhibit |=> error) else $error("err");
    a_out_keep: assert property (byteFlagEnable && access.rdEn && access.addr[15:7] != 9'h00F
        |=> $stable(byteFlagReadback)) else $error("rb");
    a_err_drop: assert property (busy && !supplyOk |=> error) else $error("err");
    cover property ($rose(busy));
    cover property (busy && !supplyOk);
    cover property ($rose(inhibit));
    cover property ($rose(error));
endmodule
bind ebfwg_core ebfwg_chk #(.SETTLE_CNT(SETTLE_CNT), .PROG_CNT(PROG_CNT)) chk (.clock,
    .rst_n, .access, .byteFlagEnable, .supplyOk, .byteFlagReadback, .inhibit, .error,
    .busy, .readReady, .writeReady);
`default_nettype wire

// >>> testbench/ebfwg_cpu.sv
// Core-side model issuing one-cycle data memory accesses
`timescale 1ns/1ps
`default_nettype none
module ebfwg_cpu
    import ebfwg_pkg::*;
(
    input wire logic clock,
    output ebfwg_access_t access
);
    initial access = '0;
    task automatic op(input logic w, input logic [15:0] a);
        @(negedge clock) access = '{w, !w, a};
        @(negedge clock) access = '0;
    endtask
endmodule
`default_nettype wire

// >>> testbench/tb_ebfwg_core.sv
// Bench for the byte flag and write guard
`timescale 1ns/1ps
`default_nettype none
module tb_ebfwg_core
    import ebfwg_pkg::*;
;
    logic clock = 0, rst_n = 0, fEn = 1, sup = 0, eClr = 0, rb, inh, err, busy, rRdy, wRdy;
    ebfwg_access_t acc;
    int miscompares = 0, samplesChecked = 0, cyc = 0;
    always #5 clock = ~clock;
    ebfwg_cpu cpu (.clock, .access(acc));
    ebfwg_core #(.SETTLE_CNT(8), .PROG_CNT(8)) uut (.clock, .rst_n, .access(acc),
        .byteFlagEnable(fEn), .supplyOk(sup), .errorClear(eClr), .byteFlagReadback(rb),
        .inhibit(inh), .error(err), .busy, .readReady(rRdy), .writeReady(wRdy));
    task automatic chk(input string n, input logic e, input logic g);
        samplesChecked++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s exp %b got %b", n, e, g);
        end
    endtask
    task automatic wrap_up;
        if (miscompares == 0 && samplesChecked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge clock) if (++cyc > 200) begin
        miscompares++;
        wrap_up;
    end
    initial begin
        repeat (3) @(negedge clock);
        rst_n = 1;
        cpu.op(1, 16'h0785);
        chk("err", 1, err);
        eClr = 1;
        @(negedge clock) eClr = 0;
        sup = 1;
        repeat (4) @(negedge clock);
        chk("inh", 0, inh);
        repeat (8) @(negedge clock);
        chk("inh", 1, inh);
        cpu.op(1, 16'h0785);
        chk("busy", 1, busy);
        chk("wrdy", 0, wRdy);
        chk("rrdy", 1, rRdy);
        // Lands while busy, so flag 6 must stay clear
        cpu.op(1, 16'h0786);
        repeat (8) @(negedge clock);
        cpu.op(0, 16'h0785);
        chk("rb", 1, rb);
        cpu.op(0, 16'h0786);
        chk("rb", 0, rb);
        cpu.op(0, 16'h0800);
        chk("rb", 0, rb);
        fEn = 0;
        @(negedge clock) chk("rb", 1, rb);
        fEn = 1;
        cpu.op(0, 16'h0785);
        chk("rb", 0, rb);
        sup = 0;
        @(negedge clock) chk("inh", 0, inh);
        sup = 1;
        repeat (10) @(negedge clock);
        cpu.op(1, 16'h0787);
        sup = 0;
        @(negedge clock) chk("err", 1, err);
        chk("busy", 0, busy);
        eClr = 1;
        cpu.op(1, 16'h0790);
        eClr = 0;
        chk("err", 1, err);
        wrap_up;
    end
endmodule
`default_nettype wire
